/* sfc_regs.svh */
// Timing counts and reset values for the SPI fault and reset control block.
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH

// ----------------------------------------------------------------------------
// Master half-bit periods in CLK cycles, one per baud select code.
// ----------------------------------------------------------------------------
`define SFC_HALF_DIV2   7'h01
`define SFC_HALF_DIV8   7'h04
`define SFC_HALF_DIV32  7'h10
`define SFC_HALF_DIV128 7'h40

// ----------------------------------------------------------------------------
// Byte framing and reset values.
// ----------------------------------------------------------------------------
`define SFC_LAST_BIT    4'h7
`define SFC_RST_MASTER  1'b1
`define SFC_RST_CPHA    1'b1
`define SFC_RST_TXEMPTY 1'b1
`define SFC_SYNC_RST    4'h8

`endif

/* sfc_pkg.sv */
// Types shared by the SPI fault and reset control block.
`default_nettype none
package sfc_pkg;

  // --------------------------------------------------------------------------
  // Software visible control and status.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic rx_ie;
    logic master_sel;
    logic cpol;
    logic cpha;
    logic wired_or;
    logic spi_en;
    logic tx_ie;
  } sfc_ctrl_t;

  typedef struct packed {
    logic       err_ie;
    logic       fault_en;
    logic [1:0] baud;
  } sfc_sctl_t;

  typedef struct packed {
    logic tx_empty;
    logic rx_full;
    logic ovr;
    logic mode_fault_flag;
  } sfc_flags_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } sfc_pins_t;

  typedef enum logic [1:0] {
    SFC_IDLE = 2'b01,
    SFC_BUSY = 2'b10
  } sfc_phase_t;

  // --------------------------------------------------------------------------
  // Module state records.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } sfc_sync_t;

  typedef struct packed {
    logic [1:0][7:0] mem;
    logic            rd;
    logic            wr;
    logic [1:0]      cnt;
  } sfc_buf_t;

  typedef struct packed {
    sfc_ctrl_t  ctrl;
    sfc_sctl_t  sctl;
    sfc_flags_t flags;
    sfc_phase_t phase;
    logic [7:0] sh;
    logic       samp;
    logic [3:0] cnt;
    logic       first;
    logic [7:0] tx_hold;
    logic [7:0] rx_data;
    logic       rx_arm;
    logic       ovr_arm;
    logic       mode_fault_flag_arm;
    logic       ss_d;
    logic       sck_d;
    logic [6:0] hcnt;
    logic       sck_lvl;
    sfc_pins_t  pins;
    logic       tx_irq;
    logic       rx_irq;
    logic       wake;
  } sfc_core_t;

endpackage : sfc_pkg
`default_nettype wire

/* sfc_sync.sv */
// Two-stage synchroniser for the four serial link inputs.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.svh"

module sfc_sync (
  input  wire logic       CLK,
  input  wire logic       SRST,
  input  wire logic [3:0] din,
  output var  logic [3:0] dout
);

  sfc_pkg::sfc_sync_t q;
  sfc_pkg::sfc_sync_t n;

  always_comb begin
    n    = q;
    n.s1 = din;
    n.s2 = q.s1;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      q.s1 <= `SFC_SYNC_RST;
      q.s2 <= `SFC_SYNC_RST;
    end else begin
      q <= n;
    end
  end

  assign dout = q.s2;

endmodule : sfc_sync
`default_nettype wire

/* sfc_buf2.sv */
// Two-entry byte buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module sfc_buf2 (
  input  wire logic       CLK,
  input  wire logic       SRST,
  input  wire logic       in_valid,
  output var  logic       in_ready,
  input  wire logic [7:0] in_data,
  output var  logic       out_valid,
  input  wire logic       out_ready,
  output var  logic [7:0] out_data
);

  sfc_pkg::sfc_buf_t q;
  sfc_pkg::sfc_buf_t n;
  logic              push;
  logic              pop;

  always_comb begin
    n    = q;
    push = in_valid && (q.cnt != 2'h2);
    pop  = out_ready && (q.cnt != 2'h0);
    if (push) begin
      n.mem[q.wr] = in_data;
      n.wr        = ~q.wr;
    end
    if (pop) begin
      n.rd = ~q.rd;
    end
    if (push && !pop) begin
      n.cnt = q.cnt + 2'h1;
    end else if (pop && !push) begin
      n.cnt = q.cnt - 2'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign in_ready  = (q.cnt != 2'h2);
  assign out_valid = (q.cnt != 2'h0);
  assign out_data  = q.mem[q.rd];

endmodule : sfc_buf2
`default_nettype wire

/* sfc_core.sv */
// SPI mode fault, transfer framing, flag clearing, partial reset and pin control.
// Behaviour
// - Slave with select rising mid-transfer sets the mode fault flag when detection is enabled.
// - Phase 0 slave: select fall starts; clock back idle after bit eight ends.
// - Phase 1 slave: clock leaving idle with select low starts the transfer.
// - Mode fault leaves master select alone; master select idle while disabled.
// - Phase 0 select then deselect faults; phase 1 without clocks does not.
// - Slave fault raises error request if enabled, never disables the module.
// - Slave ignores all clock edges while its select input is high.
// - Fault flag clears by status read then control write, with no fault.
// - Transmit empty requests interrupt only with its enable and module enabled.
// - Receive full requests interrupt with its enable, whatever the module enable.
// - Error enable lets mode fault and overflow share one request.
// - Receive full clears by status then data read; empty by data write.
// - Receive full set per received byte; empty set per shift load.
// - Disabled: empty set, transfer aborted, shifter and counter cleared, pins free.
// - Control bits and sticky flags survive disable; reset clears them but sets master select and phase.
// - Master mode fault with detection enabled disables the module.
// - Module keeps running in wait; any enabled request gives a wake request.
// - Stop freezes the module with state kept; reset aborts and resets.
// - In break, flags clear only when break clear is enabled.
// - In break without clear enable, data writes do nothing.
// - Wired-or mode drives the data output as open drain.
// - Slave output driven only as selected slave; module owns pins when enabled.
// - Master fault: error request if enabled, disable, empty set, counter cleared, pins freed.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.svh"

module sfc_core (
  input  wire logic                CLK,
  input  wire logic                SRST,
  input  wire logic                CTRL_WR,
  input  wire sfc_pkg::sfc_ctrl_t  CTRL_WDATA,
  input  wire logic                SCTL_WR,
  input  wire sfc_pkg::sfc_sctl_t  SCTL_WDATA,
  input  wire logic                STAT_RD,
  input  wire logic                DATA_RD,
  input  wire logic                DATA_WR,
  input  wire logic [7:0]          DATA_WDATA,
  input  wire logic                BREAK_ACT,
  input  wire logic                BREAK_CLEAR_ENABLE,
  input  wire logic                STOP_MODE,
  input  wire logic                SS_N_PIN,
  input  wire logic                SCK_I,
  input  wire logic                MOSI_I,
  input  wire logic                MISO_I,
  output var  sfc_pkg::sfc_ctrl_t  CTRL_Q,
  output var  sfc_pkg::sfc_sctl_t  SCTL_Q,
  output var  sfc_pkg::sfc_flags_t FLAGS_Q,
  output var  logic [7:0]          RX_DATA,
  output var  sfc_pkg::sfc_pins_t  PINS,
  output var  logic                SPI_OWNS_PINS,
  output var  logic                TX_IRQ,
  output var  logic                RX_IRQ,
  output var  logic                WAKE_REQ
);

  // --------------------------------------------------------------------------
  // State, synchronised pins and receive buffer.
  // --------------------------------------------------------------------------
  sfc_pkg::sfc_core_t q;
  sfc_pkg::sfc_core_t n;
  logic [3:0]         sy;
  logic               ss;
  logic               sck;
  logic               din;
  logic               clr_ok;
  logic               slave;
  logic               master;
  logic               lead;
  logic               trail;
  logic               done;
  logic [7:0]         byte_in;
  logic               sfault;
  logic               mfault;
  logic [6:0]         half;
  logic               buf_in_ready;
  logic               buf_out_valid;
  logic [7:0]         buf_out_data;
  logic               buf_in_valid;
  logic               buf_out_ready;

  sfc_sync u_sync (
    .CLK  (CLK),
    .SRST (SRST),
    .din  ({SS_N_PIN, SCK_I, MOSI_I, MISO_I}),
    .dout (sy)
  );

  sfc_buf2 u_buf (
    .CLK       (CLK),
    .SRST      (SRST),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (byte_in),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  function automatic logic [1:0] drive(input logic en, input logic val, input logic od);
    drive = od ? {1'b0, en && !val} : {val, en};
  endfunction : drive

  // --------------------------------------------------------------------------
  // Next state.
  // --------------------------------------------------------------------------
  always_comb begin
    n             = q;
    ss            = sy[3];
    sck           = sy[2];
    clr_ok        = !(BREAK_ACT && !BREAK_CLEAR_ENABLE);
    slave         = q.ctrl.spi_en && !q.ctrl.master_sel;
    master        = q.ctrl.spi_en && q.ctrl.master_sel;
    din           = master ? sy[0] : sy[1];
    lead          = 1'b0;
    trail         = 1'b0;
    done          = 1'b0;
    byte_in       = {q.sh[6:0], q.samp};
    sfault        = slave && (q.phase == sfc_pkg::SFC_BUSY) && !q.ss_d && ss;
    mfault        = master && q.sctl.fault_en && !ss;
    buf_out_ready = !q.flags.rx_full && !STOP_MODE;
    n.ss_d        = ss;
    n.sck_d       = sck;
    case (q.sctl.baud)
      2'h0: half = `SFC_HALF_DIV2;
      2'h1: half = `SFC_HALF_DIV8;
      2'h2: half = `SFC_HALF_DIV32;
      default: half = `SFC_HALF_DIV128;
    endcase
    if (CTRL_WR) begin
      n.ctrl = CTRL_WDATA;
    end
    if (SCTL_WR) begin
      n.sctl = SCTL_WDATA;
    end
    // Clock edges: from the pin for a selected slave, from the divider for a master.
    if (slave && !ss && (sck != q.sck_d)) begin
      lead  = (q.sck_d == q.ctrl.cpol);
      trail = (sck == q.ctrl.cpol);
    end
    if (master && (q.phase == sfc_pkg::SFC_BUSY)) begin
      n.hcnt = q.hcnt + 7'h01;
      if (q.hcnt == half - 7'h01) begin
        n.hcnt    = 7'h00;
        n.sck_lvl = !q.sck_lvl;
        lead      = !q.sck_lvl;
        trail     = q.sck_lvl;
      end
    end
    // Transfer start and shifting.
    case (q.phase)
      sfc_pkg::SFC_IDLE: begin
        if ((slave && !q.ctrl.cpha && q.ss_d && !ss) ||
            (slave && q.ctrl.cpha && lead) ||
            (master && !q.flags.tx_empty)) begin
          n.phase = sfc_pkg::SFC_BUSY;
          n.cnt   = 4'h0;
          n.first = !(slave && q.ctrl.cpha);
          if (!q.flags.tx_empty) begin
            n.sh             = q.tx_hold;
            n.flags.tx_empty = 1'b1;
          end
        end
      end
      sfc_pkg::SFC_BUSY: begin
        if (lead) begin
          if (!q.ctrl.cpha) begin
            n.samp = din;
          end else if (q.first) begin
            n.first = 1'b0;
          end else begin
            n.sh = {q.sh[6:0], q.samp};
          end
        end
        if (trail) begin
          n.cnt = q.cnt + 4'h1;
          if (q.ctrl.cpha) begin
            n.samp  = din;
            byte_in = {q.sh[6:0], din};
          end else begin
            n.sh = byte_in;
          end
          if (q.cnt == `SFC_LAST_BIT) begin
            done    = 1'b1;
            n.sh    = byte_in;
            n.phase = sfc_pkg::SFC_IDLE;
          end
        end
        if (sfault) begin
          n.phase = sfc_pkg::SFC_IDLE;
        end
      end
      default: n.phase = sfc_pkg::SFC_IDLE;
    endcase
    // Partial reset while disabled or on a master fault.
    if (!q.ctrl.spi_en || mfault) begin
      n.flags.tx_empty = 1'b1;
      n.phase          = sfc_pkg::SFC_IDLE;
      n.sh             = 8'h00;
      n.cnt            = 4'h0;
      n.hcnt           = 7'h00;
      n.sck_lvl        = 1'b0;
    end
    // Transmit data write, ignored while disabled or frozen by break.
    if (DATA_WR && clr_ok && q.ctrl.spi_en && !mfault) begin
      n.tx_hold        = DATA_WDATA;
      n.flags.tx_empty = 1'b0;
    end
    // Two-step clears; arming and clearing stop during a protected break.
    if (STAT_RD && clr_ok) begin
      n.rx_arm   = q.flags.rx_full;
      n.ovr_arm  = q.flags.ovr;
      n.mode_fault_flag_arm = q.flags.mode_fault_flag;
    end
    if (DATA_RD && clr_ok) begin
      n.rx_arm  = 1'b0;
      n.ovr_arm = 1'b0;
      if (q.rx_arm) begin
        n.flags.rx_full = 1'b0;
      end
      if (q.ovr_arm) begin
        n.flags.ovr = 1'b0;
      end
    end
    if (CTRL_WR && clr_ok && q.mode_fault_flag_arm) begin
      n.mode_fault_flag_arm   = 1'b0;
      n.flags.mode_fault_flag = 1'b0;
    end
    // Sticky sets win over clears.
    if ((sfault || mfault) && q.sctl.fault_en) begin
      n.flags.mode_fault_flag = 1'b1;
      n.mode_fault_flag_arm   = 1'b0;
    end
    if (mfault) begin
      n.ctrl.spi_en = 1'b0;
    end
    buf_in_valid = done && !q.flags.ovr && !STOP_MODE;
    if (done && !q.flags.ovr && !buf_in_ready) begin
      n.flags.ovr = 1'b1;
    end
    if (buf_out_valid && buf_out_ready) begin
      n.rx_data       = buf_out_data;
      n.flags.rx_full = 1'b1;
    end
    // Pin drive, open drain in wired-or mode.
    {n.pins.sck_o, n.pins.sck_oe}   = drive(master, q.ctrl.cpol ^ q.sck_lvl, q.ctrl.wired_or);
    {n.pins.mosi_o, n.pins.mosi_oe} = drive(master, q.sh[7], q.ctrl.wired_or);
    {n.pins.miso_o, n.pins.miso_oe} = drive(slave && !ss, q.sh[7], q.ctrl.wired_or);
    // Interrupt requests.
    n.tx_irq = q.flags.tx_empty && q.ctrl.tx_ie && q.ctrl.spi_en;
    n.rx_irq = (q.flags.rx_full && q.ctrl.rx_ie) ||
               (q.sctl.err_ie && (q.flags.mode_fault_flag || q.flags.ovr));
    n.wake   = n.tx_irq || n.rx_irq;
    if (STOP_MODE) begin
      n       = q;
      n.ss_d  = ss;
      n.sck_d = sck;
      n.pins.miso_oe = q.pins.miso_oe && !ss && !q.ctrl.master_sel;
    end
  end

  // --------------------------------------------------------------------------
  // State register; control bits and flags reset only here.
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      q                 <= '0;
      q.ctrl.master_sel <= `SFC_RST_MASTER;
      q.ctrl.cpha       <= `SFC_RST_CPHA;
      q.flags.tx_empty  <= `SFC_RST_TXEMPTY;
      q.phase           <= sfc_pkg::SFC_IDLE;
      q.ss_d            <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign CTRL_Q        = q.ctrl;
  assign SCTL_Q        = q.sctl;
  assign FLAGS_Q       = q.flags;
  assign RX_DATA       = q.rx_data;
  assign PINS          = q.pins;
  assign SPI_OWNS_PINS = q.ctrl.spi_en;
  assign TX_IRQ        = q.tx_irq;
  assign RX_IRQ        = q.rx_irq;
  assign WAKE_REQ      = q.wake;

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  a_slave_ss_fault: assert property (
    (sfault && q.sctl.fault_en && !STOP_MODE) |=> q.flags.mode_fault_flag)
    else $error("slave select rise mid-transfer did not set mode fault");

  a_fault_keeps_mode: assert property (
    ($rose(q.flags.mode_fault_flag) && !$past(CTRL_WR)) |-> $stable(q.ctrl.master_sel))
    else $error("mode fault changed master select");

  a_cpha0_start: assert property (
    (slave && !q.ctrl.cpha && q.phase == sfc_pkg::SFC_IDLE && q.ss_d && !ss
     && !STOP_MODE && !CTRL_WR) |=> q.phase == sfc_pkg::SFC_BUSY)
    else $error("phase 0 slave did not start on select fall");

  a_tx_irq_gate: assert property (
    TX_IRQ |-> $past(q.ctrl.spi_en, 1) && $past(q.ctrl.tx_ie, 1))
    else $error("transmit request without enable");

  a_err_irq: assert property (
    (q.flags.ovr && q.sctl.err_ie && !STOP_MODE) |=> RX_IRQ)
    else $error("overflow with error enable gave no request");

  a_disabled_idle: assert property (
    (!q.ctrl.spi_en && !STOP_MODE) |=> (q.flags.tx_empty && !PINS.mosi_oe
                                            && !PINS.miso_oe && !PINS.sck_oe))
    else $error("disabled module not reset to idle");

  a_master_fault: assert property (
    (mfault && !STOP_MODE) |=> (!q.ctrl.spi_en && q.flags.mode_fault_flag && q.flags.tx_empty))
    else $error("master mode fault did not disable the module");

  a_ss_high_quiet: assert property (
    (slave && ss && q.ss_d && !STOP_MODE) |=> $stable(q.cnt))
    else $error("deselected slave counted clock edges");

  a_miso_hiz: assert property (
    (ss || q.ctrl.master_sel) |=> !PINS.miso_oe)
    else $error("slave output driven while not selected");

  a_break_no_write: assert property (
    (DATA_WR && BREAK_ACT && !BREAK_CLEAR_ENABLE && !STOP_MODE) |=> $stable(q.tx_hold))
    else $error("data write took effect during protected break");

  c_byte_done: cover property (done && !q.flags.ovr);
  c_slave_fault: cover property (sfault && q.sctl.fault_en);
  c_overflow: cover property ($rose(q.flags.ovr));
  c_master_fault: cover property (mfault);

endmodule : sfc_core
`default_nettype wire

/* sfc_remote.sv */
// Far-side SPI party: a master for a slave unit, an echoing slave for a master unit.
`timescale 1ns/1ps
`default_nettype none

module sfc_remote (
  input  wire logic mosi_in,
  output var  logic ss_n,
  output var  logic sck,
  output var  logic mosi,
  output wire logic miso
);
  // --------------------------------------------------------------------------
  // Echo slave and frame generator.
  // --------------------------------------------------------------------------
  // The echoing slave returns the inverse of the bit it is given.
  assign miso = ~mosi_in;

  initial begin
    ss_n = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
  end

  // Sends n bits of b with an 80 ns clock; sel low leaves the select high.
  task automatic xfer(input logic pha, input logic pol, input logic [7:0] b,
                      input int n, input logic sel);
    ss_n = ~sel;
    sck  = pol;
    #40;
    for (int i = 0; i < n; i++) begin
      if (pha) sck = ~pol;
      mosi = b[7-i];
      #40;
      sck = pha ? pol : ~pol;
      #40;
      sck = pol;
    end
    mosi = ~mosi;
    #40;
    ss_n = 1'b1;
    #80;
  endtask : xfer
endmodule : sfc_remote
`default_nettype wire

/* sfc_core_bench.sv */
// Self-checking bench for the SPI fault and reset control core.
`timescale 1ns/1ps
`default_nettype none

module sfc_core_bench;
  // --------------------------------------------------------------------------
  // Stimulus, model and checks.
  // --------------------------------------------------------------------------
  logic clk = 1'b0, srst = 1'b1, cw = 1'b0, sw = 1'b0, sr = 1'b0, dr = 1'b0, dw = 1'b0;
  logic brk = 1'b0, bce = 1'b0, stp = 1'b0;
  logic [7:0] wd = 8'h00, seed = 8'h3c, b[4];
  sfc_pkg::sfc_ctrl_t  cd = '0;
  sfc_pkg::sfc_sctl_t  sd = '0;
  sfc_pkg::sfc_ctrl_t  cq;
  sfc_pkg::sfc_sctl_t  sq;
  sfc_pkg::sfc_flags_t fq;
  sfc_pkg::sfc_pins_t  pins;
  logic [7:0] rxd;
  logic own, txi, rxi, wk, ss_n, sck, mosi, miso;
  int n_fail = 0, check_count = 0;

  always #5 clk = ~clk;

  sfc_core dut (.CLK(clk), .SRST(srst), .CTRL_WR(cw), .CTRL_WDATA(cd), .SCTL_WR(sw),
    .SCTL_WDATA(sd), .STAT_RD(sr), .DATA_RD(dr), .DATA_WR(dw), .DATA_WDATA(wd),
    .BREAK_ACT(brk), .BREAK_CLEAR_ENABLE(bce), .STOP_MODE(stp), .SS_N_PIN(ss_n),
    .SCK_I(sck), .MOSI_I(mosi), .MISO_I(miso), .CTRL_Q(cq), .SCTL_Q(sq), .FLAGS_Q(fq),
    .RX_DATA(rxd), .PINS(pins), .SPI_OWNS_PINS(own), .TX_IRQ(txi), .RX_IRQ(rxi),
    .WAKE_REQ(wk));
  sfc_remote rem (.mosi_in(pins.mosi_o), .ss_n(ss_n), .sck(sck), .mosi(mosi), .miso(miso));

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Pulses one strobe: 0 control, 1 status control, 2 status read, 3 data read, 4 data write.
  task automatic hit(input int k);
    @(posedge clk);
    cw <= (k == 0);
    sw <= (k == 1);
    sr <= (k == 2);
    dr <= (k == 3);
    dw <= (k == 4);
    @(posedge clk);
    {cw, sw, sr, dr, dw} <= 5'h00;
    tick(4);
  endtask : hit

  task automatic ctl(input logic m, input logic pha, input logic en);
    cd <= {1'b1, m, pha, pha, 1'b0, en, 1'b1};
    hit(0);
  endtask : ctl

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end

  initial begin
    tick(3);
    srst <= 1'b0;
    tick(1);
    chk(cq, 8'h28);
    chk(fq, 8'h08);
    sd <= {1'b1, 1'b1, 2'b11};
    hit(1);
    chk(sq, 8'h0f);
    for (int p = 0; p < 2; p++) begin
      ctl(1'b0, p[0], 1'b1);
      chk(pins.miso_oe, 1'b0);
      for (int i = 0; i < 4; i++) begin
        seed = nxt(seed);
        b[i] = seed;
        #2 rem.xfer(p[0], p[0], b[i], 8, 1'b1);
        tick(6);
        chk(fq.rx_full, 1'b1);
        chk(fq.ovr, i == 3);
        chk(fq.mode_fault_flag, 1'b0);
        chk(rxi, 1'b1);
      end
      for (int i = 0; i < 3; i++) begin
        chk(rxd, b[i]);
        hit(2);
        hit(3);
      end
      chk(fq, 8'h08);
      #2 rem.xfer(p[0], p[0], 8'h00, 0, 1'b1);
      tick(4);
      chk(fq.mode_fault_flag, !p[0]);
      #2 rem.xfer(p[0], p[0], 8'ha5, 4, 1'b1);
      tick(4);
      chk(fq.mode_fault_flag, 1'b1);
      chk(cq.spi_en, 1'b1);
      chk(cq.master_sel, 1'b0);
      chk(rxi, 1'b1);
      hit(2);
      ctl(1'b0, p[0], 1'b1);
      chk(fq.mode_fault_flag, 1'b0);
      chk(rxi, 1'b0);
      $display("slave phase %0d done", p);
    end
    #2 rem.xfer(1'b1, 1'b1, 8'h3c, 8, 1'b0);
    tick(6);
    chk(fq.rx_full, 1'b0);
    ctl(1'b1, 1'b0, 1'b1);
    seed = nxt(seed);
    wd <= seed;
    hit(4);
    chk(fq.tx_empty, 1'b1);
    chk(txi, 1'b1);
    for (int i = 0; i < 3000 && !fq.rx_full; i++) tick(1);
    chk(fq.rx_full, 1'b1);
    chk(rxd, ~wd);
    chk({own, pins.sck_oe, pins.mosi_oe, pins.miso_oe}, 8'h0e);
    brk <= 1'b1;
    wd <= 8'h5a;
    @(posedge clk);
    dw <= 1'b1;
    @(posedge clk);
    dw <= 1'b0;
    #1 chk(fq.tx_empty, 1'b1);
    tick(4);
    hit(2);
    hit(3);
    chk(fq.rx_full, 1'b1);
    brk <= 1'b0;
    stp <= 1'b1;
    ctl(1'b1, 1'b0, 1'b0);
    chk(cq.spi_en, 1'b1);
    stp <= 1'b0;
    ctl(1'b1, 1'b0, 1'b0);
    chk(own, 1'b0);
    chk(pins, 8'h00);
    chk(txi, 1'b0);
    chk(rxi, 1'b1);
    chk(cq, 8'h61);
    cd <= 7'h77;
    hit(0);
    chk({pins.sck_o, pins.sck_oe}, 8'h00);
    chk(own, 1'b1);
    rem.ss_n = 1'b0;
    tick(8);
    chk(cq.spi_en, 1'b0);
    chk(cq.master_sel, 1'b1);
    chk(fq.mode_fault_flag, 1'b1);
    chk(own, 1'b0);
    chk(pins, 8'h00);
    chk(wk, 1'b1);
    rem.ss_n = 1'b1;
    $display("master done");
    wrap_up();
  end
endmodule : sfc_core_bench
`default_nettype wire
